// *** pam_cfg.svh ***
`ifndef PAM_CFG_SVH
`define PAM_CFG_SVH
// Functional notes
// - pad11: gpio, pwm6 b, serial b rx, capture4
// - pad10: gpio, pwm6 a, can b rx, adc soc b
// - pad9: gpio, pwm5 b, serial b tx, capture3
// - pad8: gpio, pwm5 a, can b tx, adc soc a
// - pad7: gpio, pwm4 b, msp a clock, capture2
// - pad6: gpio, pwm4 a, sync in, sync out
// - pad5: gpio, pwm3 b, msp a sync, capture1
// - pad4: gpio, pwm3 a, rest reserved
// - pad3: gpio, pwm2 b, capture5, msp b clock
// - pad2: gpio, pwm2 a, rest reserved
// - pad1: gpio, pwm1 b, capture6, msp b sync
// - pad0: gpio, pwm1 a, rest reserved
// - pad31: gpio, can a tx, address 17
// - pad30: gpio, can a rx, address 18
// - pad29: gpio, serial a tx, address 19
// - pad28: gpio, serial a rx, zone6 select
// - select writes need protected write enable
// - select fields read/write, reset to gpio

`define PAM_ADDR_W 8
`define PAM_LOW_OFS 8'h00
`define PAM_HIGH_OFS 8'h04
`define PAM_PADLVL_OFS 8'h08
`define PAM_LOW_RST 32'h0000_0000
`define PAM_HIGH_RST 32'h0000_0000
`define PAM_NPAD 16
`define PAM_NLOW 12
`define PAM_HIGH_BASE 24
`define PAM_PADLVL_HI 28
`define PAM_RX_IDLE 1'b1
`define PAM_IN_IDLE 1'b0
`endif

// *** pam_pad_cell.sv ***
`timescale 1ns/1ps
module pam_pad_cell (
  input wire logic [1:0] sel_i,
  input wire logic [3:0] src_o_i,
  input wire logic [3:0] src_oe_i,
  output logic pad_o,
  output logic pad_oe_o
);
  always_comb begin
    unique case (pam_pkg::pam_func_t'(sel_i))
      pam_pkg::PAM_FN_GPIO: begin
        pad_o = src_o_i[0];
        pad_oe_o = src_oe_i[0];
      end
      pam_pkg::PAM_FN_ALT1: begin
        pad_o = src_o_i[1];
        pad_oe_o = src_oe_i[1];
      end
      pam_pkg::PAM_FN_ALT2: begin
        pad_o = src_o_i[2];
        pad_oe_o = src_oe_i[2];
      end
      pam_pkg::PAM_FN_ALT3: begin
        pad_o = src_o_i[3];
        pad_oe_o = src_oe_i[3];
      end
    endcase
  end
endmodule

// *** pam_periph_model.sv ***
`timescale 1ns/1ps
module pam_periph_model (
  input wire logic [63:0] pat_i,
  input wire logic [15:0] ext_i,
  input wire logic [15:0] pad_o_i,
  input wire logic [15:0] pad_oe_i,
  output logic [42:0] src_o,
  output logic [15:0] pad_lvl_o
);
  assign src_o = pat_i[42:0];
  // board level wins only where the mux does not drive
  assign pad_lvl_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_i);
endmodule

// *** pam_pin_mux.sv ***
`timescale 1ns/1ps
`include "pam_cfg.svh"
module pam_pin_mux (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic [`PAM_ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic PROT_WR_EN_I,
  input wire logic [15:0] PAD_I,
  output logic [15:0] PAD_O,
  output logic [15:0] PAD_OE_O,
  input wire logic [15:0] GPIO_OUT_I,
  input wire logic [15:0] GPIO_OE_I,
  output logic [15:0] GPIO_IN_O,
  input wire logic [5:0] PWM_OUT_A_I,
  input wire logic [5:0] PWM_OUT_B_I,
  input wire logic PWM_SYNC_OUT_I,
  output logic PWM_SYNC_IN_O,
  input wire logic SERIAL_A_TX_I,
  output logic SERIAL_A_RX_O,
  input wire logic SERIAL_B_TX_I,
  output logic SERIAL_B_RX_O,
  input wire logic CAN_A_TX_I,
  output logic CAN_A_RX_O,
  input wire logic CAN_B_TX_I,
  output logic CAN_B_RX_O,
  input wire logic ADC_SOC_A_OUT_I,
  input wire logic ADC_SOC_B_OUT_I,
  input wire logic [5:0] CAPTURE_UNIT_O_I,
  input wire logic [5:0] CAPTURE_UNIT_OE_I,
  output logic [5:0] CAPTURE_UNIT_I_O,
  input wire logic MSP_A_RX_CLOCK_O_I,
  input wire logic MSP_A_RX_CLOCK_OE_I,
  output logic MSP_A_RX_CLOCK_I_O,
  input wire logic MSP_A_RX_FRAME_SYNC_O_I,
  input wire logic MSP_A_RX_FRAME_SYNC_OE_I,
  output logic MSP_A_RX_FRAME_SYNC_I_O,
  input wire logic MSP_B_RX_CLOCK_O_I,
  input wire logic MSP_B_RX_CLOCK_OE_I,
  output logic MSP_B_RX_CLOCK_I_O,
  input wire logic MSP_B_RX_FRAME_SYNC_O_I,
  input wire logic MSP_B_RX_FRAME_SYNC_OE_I,
  output logic MSP_B_RX_FRAME_SYNC_I_O,
  input wire logic EXT_ADDR_LINE17_I,
  input wire logic EXT_ADDR_LINE18_I,
  input wire logic EXT_ADDR_LINE19_I,
  input wire logic EXT_ZONE6_CHIP_SELECT_I
);
  // pad index: 0..11 are pads 0..11, 12..15 are pads 28..31
  logic [31:0] low_sel;
  logic [31:0] high_sel;
  logic [15:0] pad_meta_reg;
  logic [15:0] pad_sync_reg;
  logic [3:0] src_o [`PAM_NPAD];
  logic [3:0] src_oe [`PAM_NPAD];
  logic [15:0] mux_o;
  logic [15:0] mux_oe;
  logic [15:0] pad_o_reg;
  logic [15:0] pad_oe_reg;
  logic [15:0] gpio_in_reg;
  logic [5:0] cap_in_next;
  logic [5:0] cap_in_reg;
  logic [3:0] msp_in_next;
  logic [3:0] msp_in_reg;
  logic [4:0] rx_next;
  logic [4:0] rx_reg;

  function automatic logic [1:0] sel_of(input logic [31:0] lo, input logic [31:0] hi, input int p);
    if (p < `PAM_NLOW) begin
      sel_of = lo[2*p +: 2];
    end else begin
      sel_of = hi[`PAM_HIGH_BASE + 2*(p-`PAM_NLOW) +: 2];
    end
  endfunction

  function automatic logic picked(input logic [1:0] s, input pam_pkg::pam_func_t f, input logic d,
                                  input logic idle);
    picked = (pam_pkg::pam_func_t'(s) == f) ? d : idle;
  endfunction

  pam_regs u_regs (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .addr_i(ADDR_I),
    .wdata_i(WDATA_I),
    .wr_i(WR_I),
    .rd_i(RD_I),
    .prot_wr_en_i(PROT_WR_EN_I),
    .pad_lvl_i(pad_sync_reg),
    .rdata_o(RDATA_O),
    .low_o(low_sel),
    .high_o(high_sel)
  );

  // pads are asynchronous to us, two stages before anything looks
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pad_meta_reg <= 16'h0;
      pad_sync_reg <= 16'h0;
    end else begin
      pad_meta_reg <= PAD_I;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  // source order {code 11, code 10, code 01, code 00}
  // input-only entries hold oe low, output-only hold it high
  assign src_o[0] = {2'h0, PWM_OUT_A_I[0], GPIO_OUT_I[0]};
  assign src_oe[0] = {2'h0, 1'b1, GPIO_OE_I[0]};
  assign src_o[1] = {MSP_B_RX_FRAME_SYNC_O_I, CAPTURE_UNIT_O_I[5], PWM_OUT_B_I[0], GPIO_OUT_I[1]};
  assign src_oe[1] = {MSP_B_RX_FRAME_SYNC_OE_I, CAPTURE_UNIT_OE_I[5], 1'b1, GPIO_OE_I[1]};
  assign src_o[2] = {2'h0, PWM_OUT_A_I[1], GPIO_OUT_I[2]};
  assign src_oe[2] = {2'h0, 1'b1, GPIO_OE_I[2]};
  assign src_o[3] = {MSP_B_RX_CLOCK_O_I, CAPTURE_UNIT_O_I[4], PWM_OUT_B_I[1], GPIO_OUT_I[3]};
  assign src_oe[3] = {MSP_B_RX_CLOCK_OE_I, CAPTURE_UNIT_OE_I[4], 1'b1, GPIO_OE_I[3]};
  assign src_o[4] = {2'h0, PWM_OUT_A_I[2], GPIO_OUT_I[4]};
  assign src_oe[4] = {2'h0, 1'b1, GPIO_OE_I[4]};
  assign src_o[5] = {CAPTURE_UNIT_O_I[0], MSP_A_RX_FRAME_SYNC_O_I, PWM_OUT_B_I[2], GPIO_OUT_I[5]};
  assign src_oe[5] = {CAPTURE_UNIT_OE_I[0], MSP_A_RX_FRAME_SYNC_OE_I, 1'b1, GPIO_OE_I[5]};
  assign src_o[6] = {PWM_SYNC_OUT_I, 1'b0, PWM_OUT_A_I[3], GPIO_OUT_I[6]};
  assign src_oe[6] = {1'b1, 1'b0, 1'b1, GPIO_OE_I[6]};
  assign src_o[7] = {CAPTURE_UNIT_O_I[1], MSP_A_RX_CLOCK_O_I, PWM_OUT_B_I[3], GPIO_OUT_I[7]};
  assign src_oe[7] = {CAPTURE_UNIT_OE_I[1], MSP_A_RX_CLOCK_OE_I, 1'b1, GPIO_OE_I[7]};
  assign src_o[8] = {ADC_SOC_A_OUT_I, CAN_B_TX_I, PWM_OUT_A_I[4], GPIO_OUT_I[8]};
  assign src_oe[8] = {1'b1, 1'b1, 1'b1, GPIO_OE_I[8]};
  assign src_o[9] = {CAPTURE_UNIT_O_I[2], SERIAL_B_TX_I, PWM_OUT_B_I[4], GPIO_OUT_I[9]};
  assign src_oe[9] = {CAPTURE_UNIT_OE_I[2], 1'b1, 1'b1, GPIO_OE_I[9]};
  assign src_o[10] = {ADC_SOC_B_OUT_I, 1'b0, PWM_OUT_A_I[5], GPIO_OUT_I[10]};
  assign src_oe[10] = {1'b1, 1'b0, 1'b1, GPIO_OE_I[10]};
  assign src_o[11] = {CAPTURE_UNIT_O_I[3], 1'b0, PWM_OUT_B_I[5], GPIO_OUT_I[11]};
  assign src_oe[11] = {CAPTURE_UNIT_OE_I[3], 1'b0, 1'b1, GPIO_OE_I[11]};
  assign src_o[12] = {EXT_ZONE6_CHIP_SELECT_I, EXT_ZONE6_CHIP_SELECT_I, 1'b0, GPIO_OUT_I[12]};
  assign src_oe[12] = {1'b1, 1'b1, 1'b0, GPIO_OE_I[12]};
  assign src_o[13] = {EXT_ADDR_LINE19_I, EXT_ADDR_LINE19_I, SERIAL_A_TX_I, GPIO_OUT_I[13]};
  assign src_oe[13] = {1'b1, 1'b1, 1'b1, GPIO_OE_I[13]};
  assign src_o[14] = {EXT_ADDR_LINE18_I, EXT_ADDR_LINE18_I, 1'b0, GPIO_OUT_I[14]};
  assign src_oe[14] = {1'b1, 1'b1, 1'b0, GPIO_OE_I[14]};
  assign src_o[15] = {EXT_ADDR_LINE17_I, EXT_ADDR_LINE17_I, CAN_A_TX_I, GPIO_OUT_I[15]};
  assign src_oe[15] = {1'b1, 1'b1, 1'b1, GPIO_OE_I[15]};
  // reserved codes on pads 0, 2, 4 float the pad rather than guess a driver

  for (genvar p = 0; p < `PAM_NPAD; p++) begin : g_pad
    pam_pad_cell u_cell (
      .sel_i(sel_of(low_sel, high_sel, p)),
      .src_o_i(src_o[p]),
      .src_oe_i(src_oe[p]),
      .pad_o(mux_o[p]),
      .pad_oe_o(mux_oe[p])
    );
  end

  // registered so pads never see a decode glitch; costs one cycle
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pad_o_reg <= 16'h0;
      pad_oe_reg <= 16'h0;
    end else begin
      pad_o_reg <= mux_o;
      pad_oe_reg <= mux_oe;
    end
  end

  // gpio always sees the pad, whatever function owns it
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gpio_in_reg <= 16'h0;
    end else begin
      gpio_in_reg <= pad_sync_reg;
    end
  end

  // unselected receivers see their idle level, not a stray pad
  always_comb begin
    rx_next[0] = picked(sel_of(low_sel, high_sel, 11), pam_pkg::PAM_FN_ALT2, pad_sync_reg[11],
                        `PAM_RX_IDLE);
    rx_next[1] = picked(sel_of(low_sel, high_sel, 10), pam_pkg::PAM_FN_ALT2, pad_sync_reg[10],
                        `PAM_RX_IDLE);
    rx_next[2] = picked(sel_of(low_sel, high_sel, 6), pam_pkg::PAM_FN_ALT2, pad_sync_reg[6],
                        `PAM_IN_IDLE);
    rx_next[3] = picked(sel_of(low_sel, high_sel, 14), pam_pkg::PAM_FN_ALT1, pad_sync_reg[14],
                        `PAM_RX_IDLE);
    rx_next[4] = picked(sel_of(low_sel, high_sel, 12), pam_pkg::PAM_FN_ALT1, pad_sync_reg[12],
                        `PAM_RX_IDLE);
  end

  always_comb begin
    cap_in_next[0] = picked(sel_of(low_sel, high_sel, 5), pam_pkg::PAM_FN_ALT3, pad_sync_reg[5],
                            `PAM_IN_IDLE);
    cap_in_next[1] = picked(sel_of(low_sel, high_sel, 7), pam_pkg::PAM_FN_ALT3, pad_sync_reg[7],
                            `PAM_IN_IDLE);
    cap_in_next[2] = picked(sel_of(low_sel, high_sel, 9), pam_pkg::PAM_FN_ALT3, pad_sync_reg[9],
                            `PAM_IN_IDLE);
    cap_in_next[3] = picked(sel_of(low_sel, high_sel, 11), pam_pkg::PAM_FN_ALT3, pad_sync_reg[11],
                            `PAM_IN_IDLE);
    cap_in_next[4] = picked(sel_of(low_sel, high_sel, 3), pam_pkg::PAM_FN_ALT2, pad_sync_reg[3],
                            `PAM_IN_IDLE);
    cap_in_next[5] = picked(sel_of(low_sel, high_sel, 1), pam_pkg::PAM_FN_ALT2, pad_sync_reg[1],
                            `PAM_IN_IDLE);
  end

  always_comb begin
    msp_in_next[0] = picked(sel_of(low_sel, high_sel, 7), pam_pkg::PAM_FN_ALT2, pad_sync_reg[7],
                            `PAM_IN_IDLE);
    msp_in_next[1] = picked(sel_of(low_sel, high_sel, 5), pam_pkg::PAM_FN_ALT2, pad_sync_reg[5],
                            `PAM_IN_IDLE);
    msp_in_next[2] = picked(sel_of(low_sel, high_sel, 3), pam_pkg::PAM_FN_ALT3, pad_sync_reg[3],
                            `PAM_IN_IDLE);
    msp_in_next[3] = picked(sel_of(low_sel, high_sel, 1), pam_pkg::PAM_FN_ALT3, pad_sync_reg[1],
                            `PAM_IN_IDLE);
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rx_reg <= {`PAM_RX_IDLE, `PAM_RX_IDLE, `PAM_IN_IDLE, `PAM_RX_IDLE, `PAM_RX_IDLE};
      cap_in_reg <= 6'h0;
      msp_in_reg <= 4'h0;
    end else begin
      rx_reg <= rx_next;
      cap_in_reg <= cap_in_next;
      msp_in_reg <= msp_in_next;
    end
  end

  assign PAD_O = pad_o_reg;
  assign PAD_OE_O = pad_oe_reg;
  assign GPIO_IN_O = gpio_in_reg;
  assign SERIAL_B_RX_O = rx_reg[0];
  assign CAN_B_RX_O = rx_reg[1];
  assign PWM_SYNC_IN_O = rx_reg[2];
  assign CAN_A_RX_O = rx_reg[3];
  assign SERIAL_A_RX_O = rx_reg[4];
  assign CAPTURE_UNIT_I_O = cap_in_reg;
  assign MSP_A_RX_CLOCK_I_O = msp_in_reg[0];
  assign MSP_A_RX_FRAME_SYNC_I_O = msp_in_reg[1];
  assign MSP_B_RX_CLOCK_I_O = msp_in_reg[2];
  assign MSP_B_RX_FRAME_SYNC_I_O = msp_in_reg[3];
endmodule

// *** pam_pin_mux_chk.sv ***
`timescale 1ns/1ps
`include "pam_cfg.svh"
module pam_pin_mux_chk (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic [`PAM_ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic PROT_WR_EN_I,
  input wire logic [15:0] PAD_I,
  input wire logic [15:0] PAD_O,
  input wire logic [15:0] PAD_OE_O,
  input wire logic [15:0] GPIO_IN_O,
  input wire logic [5:0] PWM_OUT_A_I,
  input wire logic ADC_SOC_A_OUT_I,
  input wire logic [5:0] CAPTURE_UNIT_OE_I,
  input wire logic EXT_ADDR_LINE17_I
);
  logic [31:0] lo_reg;
  logic [31:0] hi_reg;
  // shadow selects: unprotected writes must not land
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lo_reg <= `PAM_LOW_RST;
      hi_reg <= `PAM_HIGH_RST;
    end else if (WR_I && PROT_WR_EN_I && ADDR_I == `PAM_LOW_OFS) begin
      lo_reg <= WDATA_I;
    end else if (WR_I && PROT_WR_EN_I && ADDR_I == `PAM_HIGH_OFS) begin
      hi_reg <= WDATA_I;
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  a_pad0_pwm: assert property ($past(ARST_N_I) && $past(lo_reg[1:0]) == 2'h1
    |-> PAD_OE_O[0] && PAD_O[0] == $past(PWM_OUT_A_I[0])) else $error("pad0 not on pwm");
  a_pad11_rx_only: assert property ($past(ARST_N_I) && $past(lo_reg[23:22]) == 2'h2
    |-> !PAD_OE_O[11]) else $error("pad11 driven as receiver");
  a_pad8_adc: assert property ($past(ARST_N_I) && $past(lo_reg[17:16]) == 2'h3
    |-> PAD_OE_O[8] && PAD_O[8] == $past(ADC_SOC_A_OUT_I)) else $error("pad8 not on adc strobe");
  a_pad7_capture: assert property ($past(ARST_N_I) && $past(lo_reg[15:14]) == 2'h3
    |-> PAD_OE_O[7] == $past(CAPTURE_UNIT_OE_I[1])) else $error("pad7 enable not from capture");
  a_pad31_addr: assert property ($past(ARST_N_I) && $past(hi_reg[31])
    |-> PAD_OE_O[15] && PAD_O[15] == $past(EXT_ADDR_LINE17_I)) else $error("pad31 not on address");
  a_rd_low_sel: assert property (RD_I && ADDR_I == `PAM_LOW_OFS |=> RDATA_O == $past(lo_reg))
    else $error("low select readback wrong");
  a_rd_high_sel: assert property (RD_I && ADDR_I == `PAM_HIGH_OFS |=> RDATA_O == $past(hi_reg))
    else $error("high select readback wrong");
  a_input_sync: assert property ($past(ARST_N_I, 3) |-> GPIO_IN_O == $past(PAD_I, 3))
    else $error("pad input not forwarded");
endmodule

// *** pam_pkg.sv ***
package pam_pkg;
  typedef enum logic [1:0] {
    PAM_FN_GPIO = 2'h0,
    PAM_FN_ALT1 = 2'h1,
    PAM_FN_ALT2 = 2'h2,
    PAM_FN_ALT3 = 2'h3
  } pam_func_t;
endpackage

// *** pam_regs.sv ***
`timescale 1ns/1ps
`include "pam_cfg.svh"
module pam_regs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [`PAM_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic prot_wr_en_i,
  input wire logic [15:0] pad_lvl_i,
  output logic [31:0] rdata_o,
  output logic [31:0] low_o,
  output logic [31:0] high_o
);
  logic [31:0] low_reg;
  logic [31:0] high_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_ok;

  // unprotected writes vanish silently, no error reported
  assign wr_ok = wr_i && prot_wr_en_i;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_reg <= `PAM_LOW_RST;
    end else if (wr_ok && addr_i == `PAM_LOW_OFS) begin
      low_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_reg <= `PAM_HIGH_RST;
    end else if (wr_ok && addr_i == `PAM_HIGH_OFS) begin
      high_reg <= wdata_i;
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    if (rd_i) begin
      if (addr_i == `PAM_LOW_OFS) begin
        rdata_next = low_reg;
      end else if (addr_i == `PAM_HIGH_OFS) begin
        rdata_next = high_reg;
      end else if (addr_i == `PAM_PADLVL_OFS) begin
        rdata_next[`PAM_NLOW-1:0] = pad_lvl_i[`PAM_NLOW-1:0];
        rdata_next[31:`PAM_PADLVL_HI] = pad_lvl_i[15:`PAM_NLOW];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign low_o = low_reg;
  assign high_o = high_reg;
endmodule

// *** tb_port_a_pin_function_mux.sv ***
`timescale 1ns/1ps
`include "pam_cfg.svh"
module tb_port_a_pin_function_mux;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [`PAM_ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic prot = 1'b0;
  logic [15:0] gpo = '0;
  logic [15:0] gpoe = '0;
  logic [15:0] ext = '0;
  logic [63:0] pat = '0;
  logic [31:0] lo;
  logic [31:0] hi;
  wire [31:0] rdata;
  wire [15:0] pad_o;
  wire [15:0] pad_oe;
  wire [15:0] gpi;
  wire [15:0] lvl;
  wire [42:0] src;
  wire [4:0] rx;
  wire [9:0] bi;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  // source index per pad for codes 01, 10, 11; 0 leaves the pad undriven
  byte tbl[48] = '{1, 0, 0, 7, 29, 33, 2, 0, 0, 8, 28, 32, 3, 0, 0, 9, 31, 24, 4, 0, 13, 10, 30, 25,
    5, 17, 18, 11, 15, 26, 6, 0, 19, 12, 0, 27, 0, 23, 23, 14, 22, 22, 0, 21, 21, 16, 20, 20};
  pam_periph_model u_pam_periph_model (.pat_i(pat), .ext_i(ext), .pad_o_i(pad_o), .pad_oe_i(pad_oe), .src_o(src),
    .pad_lvl_o(lvl));
  pam_pin_mux u_pam_pin_mux (.CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdata), .PROT_WR_EN_I(prot), .PAD_I(lvl), .PAD_O(pad_o), .PAD_OE_O(pad_oe),
    .GPIO_OUT_I(gpo), .GPIO_OE_I(gpoe), .GPIO_IN_O(gpi), .PWM_OUT_A_I(src[5:0]), .PWM_OUT_B_I(src[11:6]),
    .PWM_SYNC_OUT_I(src[12]), .PWM_SYNC_IN_O(rx[4]), .SERIAL_A_TX_I(src[13]), .SERIAL_A_RX_O(rx[3]),
    .SERIAL_B_TX_I(src[14]), .SERIAL_B_RX_O(rx[2]), .CAN_A_TX_I(src[15]), .CAN_A_RX_O(rx[1]),
    .CAN_B_TX_I(src[16]), .CAN_B_RX_O(rx[0]), .ADC_SOC_A_OUT_I(src[17]), .ADC_SOC_B_OUT_I(src[18]),
    .CAPTURE_UNIT_O_I(src[28:23]), .CAPTURE_UNIT_OE_I(src[34:29]), .CAPTURE_UNIT_I_O(bi[5:0]),
    .MSP_A_RX_CLOCK_O_I(src[35]), .MSP_A_RX_CLOCK_OE_I(src[39]), .MSP_A_RX_CLOCK_I_O(bi[6]),
    .MSP_A_RX_FRAME_SYNC_O_I(src[36]), .MSP_A_RX_FRAME_SYNC_OE_I(src[40]), .MSP_A_RX_FRAME_SYNC_I_O(bi[7]),
    .MSP_B_RX_CLOCK_O_I(src[37]), .MSP_B_RX_CLOCK_OE_I(src[41]), .MSP_B_RX_CLOCK_I_O(bi[8]),
    .MSP_B_RX_FRAME_SYNC_O_I(src[38]), .MSP_B_RX_FRAME_SYNC_OE_I(src[42]), .MSP_B_RX_FRAME_SYNC_I_O(bi[9]),
    .EXT_ADDR_LINE17_I(src[19]), .EXT_ADDR_LINE18_I(src[20]), .EXT_ADDR_LINE19_I(src[21]),
    .EXT_ZONE6_CHIP_SELECT_I(src[22]));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // {oe, out}: output-only sources always drive, two-way ones bring their own enable
  function automatic logic [1:0] pr(int i, logic [63:0] p);
    if (i == 0) return 2'h0;
    if (i < 24) return {1'b1, p[i-1]};
    if (i < 30) return {p[i+5], p[i-1]};
    return {p[i+9], p[i+5]};
  endfunction
  task automatic check_all();
    logic [1:0] c;
    logic [1:0] e;
    logic [4:0] erx;
    logic [9:0] ebi;
    int i;
    erx = 5'h0f;
    ebi = 10'h000;
    for (int k = 0; k < 16; k++) begin
      c = (k < 12) ? lo[2*k +: 2] : hi[2*k +: 2];
      e = {gpoe[k], gpo[k]};
      i = 0;
      if (c != 2'h0) begin
        i = int'(tbl[3*k + c - 1]);
        e = pr(i, pat);
      end
      chk(32'({pad_oe[k], pad_oe[k] & pad_o[k]}), 32'({e[1], e[1] & e[0]}));
      if (i >= 24) ebi[i-24] = lvl[k];
      case ({k[3:0], c})
        6'h1a: erx[4] = lvl[k];
        6'h31: erx[3] = lvl[k];
        6'h2e: erx[2] = lvl[k];
        6'h39: erx[1] = lvl[k];
        6'h2a: erx[0] = lvl[k];
        default: ;
      endcase
    end
    chk(32'(gpi), 32'(lvl));
    chk(32'(rx), 32'(erx));
    chk(32'(bi), 32'(ebi));
  endtask
  task automatic wr(logic [`PAM_ADDR_W-1:0] a, logic [31:0] d, logic pe);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    prot <= pe;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(logic [`PAM_ADDR_W-1:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(91));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(`PAM_LOW_OFS, `PAM_LOW_RST);
    rd(`PAM_HIGH_OFS, `PAM_HIGH_RST);
    rd(8'h0c, 32'h0);
    for (int j = 0; j < 40; j++) begin
      @(posedge clk);
      lo = (j < 4) ? {16{j[1:0]}} : $urandom;
      hi = (j < 4) ? {16{j[1:0]}} : $urandom;
      lo = lo & ~32'h0000_0222;
      pat <= {$urandom, $urandom};
      gpo <= 16'($urandom);
      gpoe <= 16'($urandom);
      ext <= 16'($urandom);
      wr(`PAM_LOW_OFS, lo, 1'b1);
      wr(`PAM_HIGH_OFS, hi, 1'b1);
      wr(`PAM_LOW_OFS, ~lo, 1'b0);
      wr(`PAM_HIGH_OFS, ~hi, 1'b0);
      wr(`PAM_PADLVL_OFS, ~lo, 1'b1);
      repeat (5) @(posedge clk);
      #1;
      check_all();
      rd(`PAM_LOW_OFS, lo);
      rd(`PAM_HIGH_OFS, hi);
      rd(`PAM_PADLVL_OFS, {lvl[15:12], 16'h0000, lvl[11:0]});
    end
    end_of_test();
  end
endmodule
bind pam_pin_mux pam_pin_mux_chk u_pam_pin_mux_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PROT_WR_EN_I(PROT_WR_EN_I), .PAD_I(PAD_I),
  .PAD_O(PAD_O), .PAD_OE_O(PAD_OE_O), .GPIO_IN_O(GPIO_IN_O), .PWM_OUT_A_I(PWM_OUT_A_I),
  .ADC_SOC_A_OUT_I(ADC_SOC_A_OUT_I), .CAPTURE_UNIT_OE_I(CAPTURE_UNIT_OE_I), .EXT_ADDR_LINE17_I(EXT_ADDR_LINE17_I));
